// file: hdl/serial_data_port.sv
`timescale 1ns/10ps
`default_nettype none
module serial_data_port
	import serial_port_pkg::*;
#(
	parameter int BIT_DIV = 100  // system clocks per sample tick (1/8 bit)
) (
	input  wire logic       clk_in,          // 25 MHz crystal clock
	input  wire logic       reset_in,        // async reset, high
	input  wire logic [1:0] frame_format_sel_in, // frame format field
	input  wire logic       sync_word_en_in, // preamble/sync enabled
	input  wire logic [5:0] pin_zero_function_sel_in, // pin 0 select
	input  wire logic [5:0] pin_one_function_sel_in,  // pin 1 select
	input  wire logic [5:0] pin_two_function_sel_in,  // pin 2 select
	input  wire logic       pin_sel_load_in, // load selects
	input  wire logic [2:0] pin_output_invert_in, // per pin invert
	input  wire logic       tx_active_in,    // radio transmitting
	input  wire logic       rx_active_in,    // radio receiving
	input  wire logic       four_level_in,   // four-level modulation
	input  wire logic       crystal_settled_in, // oscillator stable
	input  wire logic       gp_pin_zero_in,  // pin 0 input level
	input  wire logic [1:0] rx_symbol_in,    // demod symbol
	input  wire logic       rx_symbol_valid_in, // demod symbol pulse
	output logic            rx_symbol_ready_out, // demod may send
	output logic            tx_bit_out,      // bit to modulator
	output logic            tx_bit_valid_out, // modulator bit pulse
	output logic            bypass_packet_out, // packet/fifo bypass
	output logic            coding_off_out,  // no whiten/fec/manch
	output logic            insert_sync_out, // preamble insertion on
	output logic            addr_filter_en_out, // address filtering
	output logic [2:0]      gp_pin_out,      // pin output levels
	output logic [2:0]      gp_pin_oe_low_out, // pin enable, low drive
	output logic            clock_conflict_out // select rejected
);
	import serial_port_pkg::*;

	// tick counter width and wrap value
	localparam int CNT_W = $clog2(BIT_DIV + 1);
	localparam logic [CNT_W-1:0] DIV_LAST = CNT_W'(BIT_DIV - 1);

	// elaboration checks on what the counters can serve
	if (BIT_DIV < 2) begin : g_div_check
		$error("BIT_DIV must be at least 2");
	end
	if (OVERSAMPLE != 8) begin : g_os_check
		$error("phase counter serves eight samples per bit only");
	end
	if (TX_LATENCY_BITS < 2) begin : g_tx_check
		$error("transmit delay line needs two stages or more");
	end
	if (RX_LATENCY_BITS > 15) begin : g_rx_check
		$error("receive fill counter is four bits wide");
	end
	if (DIV_CNT_W < 7) begin : g_xdiv_check
		$error("divided clock counter too narrow for /192");
	end

	// internal state and decode terms
	logic [5:0]  sel_reg [3];
	logic [2:0]  conflict_flags;
	logic [CNT_W-1:0] tick_cnt_reg;
	logic        sample_tick;
	logic [2:0]  phase_reg;
	logic        bit_tick;
	logic        half_tick;
	logic        async_mode;
	logic        sync_mode;
	link_state_t state_reg;
	logic [TX_LATENCY_BITS-1:0] tx_pipe_reg;
	logic [3:0]  rx_fill_reg;
	logic        rx_data_reg;
	logic [1:0]  hard_reg;
	logic        strobe_reg;
	logic        tx_sample_reg;
	logic        serial_clk;
	logic        buf_valid;
	logic [1:0]  buf_data;
	logic        buf_take;
	logic        pin0_input;
	logic [DIV_CNT_W-1:0] xdiv_cnt_reg;
	logic        xdiv_reg;
	logic [5:0]  div_sel;
	logic        div_active;
	logic [DIV_CNT_W-1:0] div_half;
	logic        ready_low_reg;

	// divided clock half period in crystal cycles; /1 and /1.5
	// cannot be made by toggling a flop, so both run as /2
	function automatic logic [DIV_CNT_W-1:0] half_period(
		input logic [5:0] code);
		case (code)
			6'h30, 6'h31: half_period = 9'd1;
			6'h32: half_period = 9'd1;
			6'h33: half_period = 9'd2;
			6'h34: half_period = 9'd2;
			6'h35: half_period = 9'd3;
			6'h36: half_period = 9'd3;
			6'h37: half_period = 9'd6;
			6'h38: half_period = 9'd8;
			6'h39: half_period = 9'd12;
			6'h3a: half_period = 9'd16;
			6'h3b: half_period = 9'd24;
			6'h3c: half_period = 9'd32;
			6'h3d: half_period = 9'd48;
			6'h3e: half_period = 9'd64;
			default: half_period = 9'd96;
		endcase
	endfunction

	// every code from the first divided clock upward is a clock
	function automatic logic is_div(input logic [5:0] code);
		is_div = (code >= SEL_DIV_FIRST);
	endfunction

	// mode decode
	// any other frame format is normal packet mode
	assign async_mode = (frame_format_sel_in == FMT_ASYNC_SERIAL); // [RQ6]
	assign sync_mode = (frame_format_sel_in == FMT_SYNC_SERIAL); // [RQ27]
	assign bypass_packet_out = async_mode; // [RQ7]
	assign coding_off_out = async_mode; // [RQ8]
	assign insert_sync_out = sync_mode && sync_word_en_in; // [RQ16] [RQ19]
	assign addr_filter_en_out = !sync_mode && !async_mode; // [RQ18]

	// a load offering divided clocks on two pins is refused whole,
	// so a pin never shows a second divided clock
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			conflict_flags[i] = 1'b0;
		end
		conflict_flags[0] = is_div(pin_zero_function_sel_in) &&
			(is_div(pin_one_function_sel_in) ||
			 is_div(pin_two_function_sel_in)); // [RQ1]
		conflict_flags[1] = is_div(pin_one_function_sel_in) &&
			is_div(pin_two_function_sel_in); // [RQ1]
		conflict_flags[2] = 1'b0;
	end

	// pin select registers
	// a refused load keeps all three selects; the flag says why
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			sel_reg[0] <= PIN0_RESET_SEL; // [RQ2]
			sel_reg[1] <= PIN1_RESET_SEL;
			sel_reg[2] <= PIN2_RESET_SEL;
			clock_conflict_out <= 1'b0;
		end else if (pin_sel_load_in) begin
			// the flag is rewritten by every load
			clock_conflict_out <= |conflict_flags;
			if (!(|conflict_flags)) begin // [RQ1]
				sel_reg[0] <= pin_zero_function_sel_in;
				sel_reg[1] <= pin_one_function_sel_in;
				sel_reg[2] <= pin_two_function_sel_in;
			end
		end
	end

	// sample tick divider, eight ticks per bit
	// phase counts sample ticks and wraps once per bit
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			tick_cnt_reg <= '0;
			phase_reg <= 3'd0;
		end else if (tick_cnt_reg == DIV_LAST) begin
			tick_cnt_reg <= '0;
			phase_reg <= phase_reg + 3'd1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + CNT_W'(1);
		end
	end
	assign sample_tick = (tick_cnt_reg == DIV_LAST); // [RQ10]
	assign bit_tick = sample_tick && (phase_reg == 3'(OVERSAMPLE - 1));
	assign half_tick = sample_tick && (phase_reg == 3'(OVERSAMPLE/2 - 1));
	// low in first half, rises mid-bit for sampling, falls at bit start
	assign serial_clk = phase_reg[2]; // [RQ12] [RQ23]

	// link state
	// transmit wins when both radio states rise together;
	// a receive under way is not cut short by transmit
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_reg <= LINK_IDLE;
		end else begin
			case (state_reg)
				LINK_IDLE: begin
					if (tx_active_in) state_reg <= LINK_TX;
					else if (rx_active_in) state_reg <= LINK_RX;
				end
				LINK_TX: begin
					if (!tx_active_in) state_reg <= LINK_IDLE;
				end
				LINK_RX: begin
					if (!rx_active_in) state_reg <= LINK_IDLE;
				end
				default: state_reg <= LINK_IDLE;
			endcase
		end
	end

	// pin zero becomes input while transmitting in serial modes
	// normal mode leaves pin zero an output unless its select is high-z
	assign pin0_input = (state_reg == LINK_TX) &&
		(sync_mode || async_mode); // [RQ9] [RQ13]

	// transmit: async oversampled, sync sampled at rising clock edge
	// async forwards every sample raw to the modulator;
	// sync catches the bit at the rising serial clock and
	// lets it out of the delay line eight bits later
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			tx_sample_reg <= 1'b0;
			tx_pipe_reg <= '0;
			tx_bit_out <= 1'b0;
			tx_bit_valid_out <= 1'b0;
		end else begin
			tx_bit_valid_out <= 1'b0;
			if (pin0_input && async_mode && sample_tick) begin
				tx_bit_out <= gp_pin_zero_in; // [RQ10]
				tx_bit_valid_out <= 1'b1;
			end
			// rising serial clock: host data has settled
			if (pin0_input && sync_mode && half_tick) begin
				tx_sample_reg <= gp_pin_zero_in; // [RQ23]
			end
			// bit start: shift the delay line
			if (pin0_input && sync_mode && bit_tick) begin
				tx_pipe_reg <= {tx_pipe_reg[TX_LATENCY_BITS-2:0],
					tx_sample_reg};
				tx_bit_out <= tx_pipe_reg[TX_LATENCY_BITS-1]; // [RQ14]
				tx_bit_valid_out <= 1'b1;
			end
		end
	end

	// symbol buffer between demodulator and outputs
	// one word leaves per bit tick; the second entry holds a
	// word that arrives while the head waits, so none is lost
	skid_buffer #(.WIDTH(2)) sym_buf (
		.clk_in     (clk_in),
		.reset_in   (reset_in),
		.s_valid_in (rx_symbol_valid_in),
		.s_ready_out(rx_symbol_ready_out),
		.s_data_in  (rx_symbol_in),
		.m_valid_out(buf_valid),
		.m_ready_in (buf_take),
		.m_data_out (buf_data)
	);
	assign buf_take = bit_tick;

	// receive: data and hard decisions change at bit start
	// the fill counter stops at its limit so it never wraps;
	// two-level symbols carry data in the upper bit only
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rx_fill_reg <= 4'd0;
			rx_data_reg <= 1'b0;
			hard_reg <= 2'b00;
			strobe_reg <= 1'b0;
		end else begin
			// fill counts bits since reception started
			if (state_reg != LINK_RX) begin
				rx_fill_reg <= 4'd0;
			end else if (bit_tick &&
				rx_fill_reg != 4'(RX_LATENCY_BITS)) begin
				rx_fill_reg <= rx_fill_reg + 4'd1; // [RQ15]
			end
			// a new symbol each bit tick; the strobe falls mid-symbol
			if (bit_tick && buf_valid) begin
				hard_reg <= four_level_in ? buf_data
					: {buf_data[1], 1'b0}; // [RQ20]
				strobe_reg <= 1'b1; // [RQ21] [RQ22]
				if (rx_fill_reg == 4'(RX_LATENCY_BITS - 1) ||
					rx_fill_reg == 4'(RX_LATENCY_BITS)) begin
					rx_data_reg <= buf_data[1]; // [RQ15]
				end
			end else if (half_tick) begin
				strobe_reg <= 1'b0; // [RQ21]
			end
		end
	end

	// divided crystal clock, one generator shared by the pins
	// at most one pin can hold a divided clock, so sharing is safe
	always_comb begin
		div_sel = SEL_DIV_192;
		div_active = 1'b0;
		// lowest pin index wins
		for (int i = 2; i >= 0; i--) begin
			if (is_div(sel_reg[i])) begin
				div_sel = sel_reg[i];
				div_active = 1'b1;
			end
		end
	end
	assign div_half = half_period(div_sel);

	// counter restarts while no pin shows a divided clock;
	// ready flag is registered so the pin never glitches
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			xdiv_cnt_reg <= '0;
			xdiv_reg <= 1'b0;
			ready_low_reg <= 1'b1;
		end else begin
			ready_low_reg <= !crystal_settled_in;
			if (!div_active) begin
				xdiv_cnt_reg <= '0;
			end else if (xdiv_cnt_reg + 9'd1 >= div_half) begin
				xdiv_cnt_reg <= '0;
				xdiv_reg <= ~xdiv_reg;
			end else begin
				xdiv_cnt_reg <= xdiv_cnt_reg + 9'd1;
			end
		end
	end

	// output selector per pin
	// codes with no source in this block read as low
	function automatic logic pin_level(input logic [5:0] code);
		if (code == SEL_SERIAL_CLK) pin_level = serial_clk;
		else if (code == SEL_SYNC_DATA) pin_level = rx_data_reg; // [RQ24]
		else if (code == SEL_ASYNC_DATA) pin_level = hard_reg[1]; // [RQ25]
		else if (code == SEL_HARD_HI) pin_level = hard_reg[1];
		else if (code == SEL_HARD_LO) pin_level = hard_reg[0];
		else if (code == SEL_SYM_STROBE) pin_level = strobe_reg; // [RQ26]
		else if (code == SEL_DEV_READY) pin_level = ready_low_reg;
		else if (code == SEL_XTAL_SETTLED) pin_level = !ready_low_reg;
		else if (code == SEL_DRIVE_EN) pin_level = !pin0_input; // [RQ3]
		else if (code == SEL_CONST_LOW) pin_level = 1'b0; // [RQ4]
		else if (is_div(code)) pin_level = xdiv_reg;
		else pin_level = 1'b0;
	endfunction

	// a high-z select releases the pin; transmit in serial
	// modes releases pin zero whatever its select says
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			gp_pin_out[i] = pin_level(sel_reg[i]) ^ pin_output_invert_in[i];
			gp_pin_oe_low_out[i] = (sel_reg[i] == SEL_HIGH_Z);
		end
		if (pin0_input) begin
			gp_pin_oe_low_out[0] = 1'b1; // [RQ9] [RQ13]
		end
	end
endmodule // serial_data_port
`default_nettype wire

// file: hdl/serial_port_pkg.sv
// Summary of operation
// RQ1: one divided crystal clock on pins
// RQ2: pin zero resets to crystal divided 192
// RQ3: code 0x2D shows pin zero drive enable
// RQ4: code 0x2F drives constant level, invertible
// RQ5: host avoids divided clocks during radio activity
// RQ6: frame format 3 selects asynchronous mode
// RQ7: asynchronous mode bypasses packet and buffer
// RQ8: asynchronous mode has no coding features
// RQ9: async transmit input on pin zero
// RQ10: transmit input sampled eight times per bit
// RQ11: host bit period error below one eighth
// RQ12: synchronous mode supplies bit clock
// RQ13: pin zero becomes input during sync transmit
// RQ14: sync transmit latency eight bit periods
// RQ15: sync receive data after nine bits
// RQ16: preamble and sync follow sync mode
// RQ17: host handles preamble when sync off
// RQ18: packet features kept, no address filter
// RQ19: device adds preamble, host sends payload
// RQ20: hard decision two bits, upper for binary
// RQ21: symbol strobe high half symbol period
// RQ22: strobe and decisions usable either mode
// RQ23: serial clock falling sets up receive data
// RQ24: code 0x0C routes sync receive data
// RQ25: code 0x0D routes async receive data
// RQ26: code 0x1D routes symbol strobe
// RQ27: frame format 1 selects synchronous mode
package serial_port_pkg;
	localparam logic [5:0] SEL_SERIAL_CLK   = 6'h0b;
	localparam logic [5:0] SEL_SYNC_DATA    = 6'h0c;
	localparam logic [5:0] SEL_ASYNC_DATA   = 6'h0d;
	localparam logic [5:0] SEL_HARD_HI      = 6'h16;
	localparam logic [5:0] SEL_HARD_LO      = 6'h17;
	localparam logic [5:0] SEL_SYM_STROBE   = 6'h1d;
	localparam logic [5:0] SEL_DEV_READY    = 6'h29;
	localparam logic [5:0] SEL_XTAL_SETTLED = 6'h2b;
	localparam logic [5:0] SEL_DRIVE_EN     = 6'h2d;
	localparam logic [5:0] SEL_HIGH_Z       = 6'h2e;
	localparam logic [5:0] SEL_CONST_LOW    = 6'h2f;
	localparam logic [5:0] SEL_DIV_FIRST    = 6'h30;
	localparam logic [5:0] SEL_DIV_192      = 6'h3f;
	localparam logic [5:0] PIN0_RESET_SEL   = SEL_DIV_192;
	localparam logic [5:0] PIN1_RESET_SEL   = SEL_HIGH_Z;
	localparam logic [5:0] PIN2_RESET_SEL   = 6'h29;
	localparam logic [1:0] FMT_NORMAL       = 2'h0;
	localparam logic [1:0] FMT_SYNC_SERIAL  = 2'h1;
	localparam logic [1:0] FMT_ASYNC_SERIAL = 2'h3;
	localparam int OVERSAMPLE      = 8;
	localparam int TX_LATENCY_BITS = 8;
	localparam int RX_LATENCY_BITS = 9;
	localparam int DIV_CNT_W       = 9;
	typedef enum logic [1:0] {
		LINK_IDLE = 2'b00,
		LINK_TX   = 2'b01,
		LINK_RX   = 2'b10
	} link_state_t;
endpackage

// file: hdl/skid_buffer.sv
`timescale 1ns/10ps
`default_nettype none
module skid_buffer #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk_in,    // system clock
	input  wire logic             reset_in,  // async reset
	input  wire logic             s_valid_in, // source valid
	output logic                  s_ready_out, // room available
	input  wire logic [WIDTH-1:0] s_data_in, // source word
	output logic                  m_valid_out, // word present
	input  wire logic             m_ready_in, // sink accepts
	output logic [WIDTH-1:0]      m_data_out // head word
);
	logic [WIDTH-1:0] mem_reg [2];
	logic             rd_ptr_reg;
	logic             wr_ptr_reg;
	logic [1:0]       count_reg;
	logic             push;
	logic             pop;

	if (WIDTH < 1) begin : g_width_check
		$error("skid_buffer width must be positive");
	end

	// handshake terms
	assign s_ready_out = (count_reg != 2'd2);
	assign m_valid_out = (count_reg != 2'd0);
	assign push = s_valid_in && s_ready_out;
	assign pop = m_valid_out && m_ready_in;
	assign m_data_out = mem_reg[rd_ptr_reg];

	// storage
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= s_data_in;
		end
	end

	// pointers and occupancy
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rd_ptr_reg <= 1'b0;
			wr_ptr_reg <= 1'b0;
			count_reg <= 2'd0;
		end else begin
			if (push) wr_ptr_reg <= ~wr_ptr_reg;
			if (pop) rd_ptr_reg <= ~rd_ptr_reg;
			count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // skid_buffer
`default_nettype wire

// file: verif/host_serial_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_serial_model #(
	parameter int BIT_CLKS = 16 // clocks per serial bit
) (
	input  wire logic       clk_in,       // clock
	input  wire logic       send_in,      // host sends
	input  wire logic [7:0] byte_in,      // repeated byte
	input  wire logic       oe_low_in,    // device enable, low drive
	input  wire logic       dev_level_in, // device level
	output logic            wire_out      // resolved pin
);
	int         cnt_reg = 0;
	logic [2:0] bit_reg = 3'h0;
	logic       wiggle_reg = 1'b0;
	logic       host_level;
	// exact bit period, msb first; raw stream, framing is ours
	always @(posedge clk_in) begin
		wiggle_reg <= ~wiggle_reg;
		if (!send_in || cnt_reg == BIT_CLKS - 1) cnt_reg <= 0;
		else cnt_reg <= cnt_reg + 1;
		if (!send_in) bit_reg <= 3'h0;
		else if (cnt_reg == BIT_CLKS - 1) bit_reg <= bit_reg + 3'h1;
	end
	// released line has no pull, so it changes every cycle
	assign host_level = send_in ? byte_in[3'h7 - bit_reg] : wiggle_reg;
	// host data reaches pin zero only while the device lets go
	assign wire_out = oe_low_in ? host_level : dev_level_in;
endmodule // host_serial_model
`default_nettype wire

// file: verif/serial_data_port_props.sv
`timescale 1ns/10ps
`default_nettype none
module serial_data_port_props
	import serial_port_pkg::*;
(
	input wire logic       clk_in,                   // clock
	input wire logic       reset_in,                 // reset
	input wire logic [1:0] frame_format_sel_in,      // format
	input wire logic       sync_word_en_in,          // sync on
	input wire logic [5:0] pin_zero_function_sel_in, // pin 0 sel
	input wire logic [5:0] pin_one_function_sel_in,  // pin 1 sel
	input wire logic [5:0] pin_two_function_sel_in,  // pin 2 sel
	input wire logic       pin_sel_load_in,          // load
	input wire logic [2:0] pin_output_invert_in,     // invert
	input wire logic       tx_active_in,             // tx on
	input wire logic       tx_bit_valid_out,         // bit pulse
	input wire logic       bypass_packet_out,        // bypass
	input wire logic       coding_off_out,           // no coding
	input wire logic       insert_sync_out,          // sync insert
	input wire logic       addr_filter_en_out,       // filter
	input wire logic [2:0] gp_pin_out,               // pins
	input wire logic [2:0] gp_pin_oe_low_out,        // enables
	input wire logic       clock_conflict_out        // rejected
);
	logic [5:0] s0_reg;
	logic [5:0] s1_reg;
	logic [5:0] s2_reg;
	logic [1:0] ndiv;
	// divided-clock codes in the offered load
	assign ndiv = 2'(pin_zero_function_sel_in >= SEL_DIV_FIRST)
		+ 2'(pin_one_function_sel_in >= SEL_DIV_FIRST)
		+ 2'(pin_two_function_sel_in >= SEL_DIV_FIRST);
	// selects that the block should hold
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			s0_reg <= PIN0_RESET_SEL;
			s1_reg <= PIN1_RESET_SEL;
			s2_reg <= PIN2_RESET_SEL;
		end else if (pin_sel_load_in && ndiv < 2'h2) begin
			s0_reg <= pin_zero_function_sel_in;
			s1_reg <= pin_one_function_sel_in;
			s2_reg <= pin_two_function_sel_in;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	sequence sync_tx_s;
		frame_format_sel_in == FMT_SYNC_SERIAL && tx_active_in;
	endsequence
	a_conflict_flag: assert property (
		pin_sel_load_in |=> clock_conflict_out == $past(ndiv > 2'h1))
		else $error("conflict flag wrong after load");
	a_const_level: assert property (
		s1_reg == SEL_CONST_LOW |-> gp_pin_out[1] == pin_output_invert_in[1])
		else $error("constant level wrong");
	a_drive_flag: assert property (
		s2_reg == SEL_DRIVE_EN && s0_reg != SEL_HIGH_Z
		|-> gp_pin_out[2] == (!gp_pin_oe_low_out[0] ^ pin_output_invert_in[2]))
		else $error("drive enable flag wrong");
	a_drive_low_tx: assert property (
		sync_tx_s [*3] ##0 s2_reg == SEL_DRIVE_EN
		|-> gp_pin_out[2] == pin_output_invert_in[2])
		else $error("drive enable flag high during transmit");
	a_async_bypass: assert property (
		frame_format_sel_in == FMT_ASYNC_SERIAL
		|-> bypass_packet_out && coding_off_out)
		else $error("async mode keeps packet path");
	a_sync_filter: assert property (
		frame_format_sel_in == FMT_SYNC_SERIAL |-> !addr_filter_en_out)
		else $error("address filter on in sync mode");
	a_sync_insert: assert property (
		frame_format_sel_in == FMT_SYNC_SERIAL
		|-> insert_sync_out == sync_word_en_in)
		else $error("sync insertion not following enable");
	a_tx_pin_input: assert property (
		sync_tx_s [*3] |-> gp_pin_oe_low_out[0])
		else $error("pin zero driven during sync transmit");
	a_valid_pulse: assert property (
		tx_bit_valid_out |=> !tx_bit_valid_out)
		else $error("bit pulse longer than one cycle");
endmodule // serial_data_port_props
`default_nettype wire

// file: verif/serial_data_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module serial_data_port_tb;
	import serial_port_pkg::*;
	localparam int BD = 2;
	localparam int BITC = 8 * BD;
	logic       clk_in = 1'b0;
	logic       reset_in = 1'b1;
	logic [1:0] fmt = FMT_NORMAL;
	logic       sync_en = 1'b0;
	logic [5:0] sel0 = 6'h00;
	logic [5:0] sel1 = 6'h00;
	logic [5:0] sel2 = 6'h00;
	logic       load = 1'b0;
	logic [2:0] inv = 3'h0;
	logic       tx_act = 1'b0;
	logic       rx_act = 1'b0;
	logic       four = 1'b0;
	logic       settled = 1'b0;
	logic       sym_valid = 1'b0;
	logic       send = 1'b0;
	logic       full_seen = 1'b0;
	wire logic  pin0_wire;
	logic       sym_ready, tx_bit, tx_valid, bypass, coding_off;
	logic       ins_sync, addr_filt, conflict;
	logic [2:0] pins, oe_low;
	int         fails = 0;
	int         comparisons = 0;
	serial_data_port #(.BIT_DIV(BD)) i_dut (
		.clk_in(clk_in), .reset_in(reset_in), .frame_format_sel_in(fmt),
		.sync_word_en_in(sync_en), .pin_zero_function_sel_in(sel0),
		.pin_one_function_sel_in(sel1), .pin_two_function_sel_in(sel2),
		.pin_sel_load_in(load), .pin_output_invert_in(inv),
		.tx_active_in(tx_act), .rx_active_in(rx_act), .four_level_in(four),
		.crystal_settled_in(settled), .gp_pin_zero_in(pin0_wire),
		.rx_symbol_in(2'h3), .rx_symbol_valid_in(sym_valid),
		.rx_symbol_ready_out(sym_ready), .tx_bit_out(tx_bit),
		.tx_bit_valid_out(tx_valid), .bypass_packet_out(bypass),
		.coding_off_out(coding_off), .insert_sync_out(ins_sync),
		.addr_filter_en_out(addr_filt), .gp_pin_out(pins),
		.gp_pin_oe_low_out(oe_low), .clock_conflict_out(conflict));
	host_serial_model #(.BIT_CLKS(BITC)) i_host (
		.clk_in(clk_in), .send_in(send), .byte_in(8'hf0),
		.oe_low_in(oe_low[0]), .dev_level_in(pins[0]),
		.wire_out(pin0_wire));
	// clock, buffer-full watch and watchdog
	always #20 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		if (sym_valid && sym_ready === 1'b0) full_seen <= 1'b1;
	end
	initial begin
		repeat (10000) @(posedge clk_in);
		fails++;
		complete_run();
	end
	task automatic chk(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic setm(input logic [1:0] f, input logic t, input logic r);
		@(posedge clk_in);
		fmt <= f;
		tx_act <= t;
		rx_act <= r;
	endtask
	task automatic load_sel(input logic [5:0] a, input logic [5:0] b,
		input logic [5:0] c);
		@(posedge clk_in);
		sel0 <= a;
		sel1 <= b;
		sel2 <= c;
		load <= 1'b1;
		@(posedge clk_in);
		load <= 1'b0;
		@(posedge clk_in);
		#1;
	endtask
	task automatic measure(input int idx, input int n, output int rises,
		output int highs);
		logic prev;
		rises = 0;
		highs = 0;
		prev = pins[idx];
		repeat (n) begin
			@(posedge clk_in);
			#1;
			if (pins[idx] === 1'b1 && prev === 1'b0) rises++;
			if (pins[idx] === 1'b1) highs++;
			prev = pins[idx];
		end
	endtask
	task automatic complete_run;
		if (fails == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// main sequence; divided clocks only while the radio idles
	initial begin
		int r, h, v, ones;
		repeat (10) @(posedge clk_in);
		reset_in <= 1'b0;
		measure(0, 384, r, h);
		chk("div192 rises", 8'(r), 8'h02);
		load_sel(SEL_DIV_192, SEL_CONST_LOW, SEL_DEV_READY);
		for (int i = 1; i >= 0; i--) begin
			@(posedge clk_in);
			inv <= {1'b0, i[0], 1'b0};
			settled <= !i[0];
			@(posedge clk_in);
			#1;
			chk("const level", {7'h0, pins[1]}, {7'h0, i[0]});
			chk("ready low", {7'h0, pins[2]}, {7'h0, i[0]});
		end
		load_sel(6'h30, 6'h31, SEL_DEV_READY);
		chk("conflict set", {7'h0, conflict}, 8'h01);
		chk("pin1 kept", {7'h0, pins[1]}, 8'h00);
		measure(0, 384, r, h);
		chk("div kept", 8'(r), 8'h02);
		load_sel(6'h32, SEL_CONST_LOW, SEL_DEV_READY);
		chk("conflict clear", {7'h0, conflict}, 8'h00);
		measure(0, 20, r, h);
		chk("div2 rises", 8'(r), 8'h0a);
		// async transmit from the host through pin zero
		load_sel(SEL_HIGH_Z, SEL_CONST_LOW, SEL_DEV_READY);
		setm(FMT_ASYNC_SERIAL, 1'b1, 1'b0);
		send <= 1'b1;
		repeat (16 * BITC) @(posedge clk_in);
		v = 0;
		ones = 0;
		repeat (8 * BITC) begin
			@(posedge clk_in);
			#1;
			if (tx_valid === 1'b1) v++;
			if (tx_valid === 1'b1 && tx_bit === 1'b1) ones++;
		end
		chk("sample ticks", 8'(v), 8'(8 * BITC / BD));
		chk("sampled ones", 8'(ones), 8'(4 * BITC / BD));
		chk("bypass", {6'h0, bypass, coding_off}, 8'h03);
		send <= 1'b0;
		// sync transmit: bit clock, pin zero turned round
		setm(FMT_SYNC_SERIAL, 1'b1, 1'b0);
		load_sel(SEL_HIGH_Z, SEL_SERIAL_CLK, SEL_DRIVE_EN);
		chk("pin0 input", {7'h0, oe_low[0]}, 8'h01);
		chk("drive flag", {7'h0, pins[2]}, 8'h00);
		measure(1, 10 * BITC, r, h);
		chk("bit clock", 8'(r), 8'h0a);
		chk("clock half", 8'(h), 8'(5 * BITC));
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_in);
			sync_en <= i[0];
			@(posedge clk_in);
			#1;
			chk("sync insert", {7'h0, ins_sync}, {7'h0, i[0]});
			chk("addr filter", {7'h0, addr_filt}, 8'h00);
		end
		setm(FMT_SYNC_SERIAL, 1'b0, 1'b0);
		load_sel(SEL_SYNC_DATA, SEL_SERIAL_CLK, SEL_DRIVE_EN);
		chk("drive flag", {7'h0, pins[2]}, 8'h01);
		// receive symbols in both serial modes, buffer held full
		for (int f = 0; f < 2; f++) begin
			setm(f ? FMT_SYNC_SERIAL : FMT_ASYNC_SERIAL, 1'b0, 1'b1);
			four <= f[0];
			sym_valid <= 1'b1;
			load_sel(SEL_HARD_HI, SEL_HARD_LO, SEL_SYM_STROBE);
			repeat (4 * BITC) @(posedge clk_in);
			#1;
			chk("hard hi", {7'h0, pins[0]}, 8'h01);
			chk("hard lo", {7'h0, pins[1]}, {7'h0, f[0]});
			measure(2, 10 * BITC, r, h);
			chk("strobe half", 8'(h), 8'(5 * BITC));
			load_sel(f ? SEL_SYNC_DATA : SEL_ASYNC_DATA, SEL_HARD_LO,
				SEL_SYM_STROBE);
			chk("rx data", {7'h0, pins[0]}, 8'h01);
		end
		chk("buffer full", {7'h0, full_seen}, 8'h01);
		@(posedge clk_in);
		sym_valid <= 1'b0;
		repeat (4 * BITC) @(posedge clk_in);
		#1;
		chk("drained", {7'h0, sym_ready}, 8'h01);
		complete_run();
	end
endmodule // serial_data_port_tb
bind serial_data_port serial_data_port_props i_props (
	.clk_in(clk_in), .reset_in(reset_in),
	.frame_format_sel_in(frame_format_sel_in),
	.sync_word_en_in(sync_word_en_in),
	.pin_zero_function_sel_in(pin_zero_function_sel_in),
	.pin_one_function_sel_in(pin_one_function_sel_in),
	.pin_two_function_sel_in(pin_two_function_sel_in),
	.pin_sel_load_in(pin_sel_load_in),
	.pin_output_invert_in(pin_output_invert_in),
	.tx_active_in(tx_active_in), .tx_bit_valid_out(tx_bit_valid_out),
	.bypass_packet_out(bypass_packet_out), .coding_off_out(coding_off_out),
	.insert_sync_out(insert_sync_out),
	.addr_filter_en_out(addr_filter_en_out), .gp_pin_out(gp_pin_out),
	.gp_pin_oe_low_out(gp_pin_oe_low_out),
	.clock_conflict_out(clock_conflict_out));
`default_nettype wire
